// File: rtl/fsac_core.sv
// Flash space access control: sequencing, status, read mapping, protection
// Operation
// - Write-active flag sets at programming start, clears at completion.
// - Non-consecutive second write, or one with a key other than the first or second, sets the sequence error flag.
// - User or extra row write, or latch reset, with no loaded latches sets the sequence error flag.
// - Software clears the error flag; a correct sequence also clears it.
// - Power-down deselects flash and clears loaded latches and their flag.
// - Power-down requests are ignored while the write-active flag is set.
// - Upper bank target picks which bank answers upper 32K code reads.
// - Hardware boot entry maps boot ROM for code reads by default.
// - Control value 01h maps extra row bytes for pointers 0000h-007Fh.
// - Control value 04h maps the security byte at pointer 0000h.
// - Control value 05h maps the fuse byte at pointer 0000h.
// - Clearing control to zero returns code reads to user flash.
// - Data writes go to latches only with latch map set and pin high.
// - Execution from external memory with pin low reads external code only.
// - External upper bank reads external from 8000h unless level 4; below depends on lock.
// - Three lock bits in security byte default to protection level 4.
// - Unprogrammed gives level 1; bit 0, 1, 2 programmed give 2, 3, 4.
// - Level 2 blocks external reads, latches pin, stops parallel programming.
// - Level 3 adds parallel verify off and in-system reads refused.
// - Level 4 adds external execution disabled.
// - Boot ROM fetches are allowed only during the boot process.
`timescale 1ns/1ps
`default_nettype none
`include "fsac_defines.svh"

module fsac_core
   import fsac_pkg::*;
#(
   parameter int PROG_CYCLES = (`FSAC_PROG_TIME_US * `FSAC_CLK_MHZ)
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // Avalon-MM slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic [1:0] o_avs_response,
   // Core events
   input wire logic i_other_instr,
   input wire logic i_powerdown_req,
   input wire logic i_boot_hw_entry,
   input wire logic i_boot_active,
   input wire logic i_ext_access_pin,
   // Data space writes
   input wire logic i_xwrite,
   input wire logic [15:0] i_xwrite_addr,
   output logic o_xwrite_to_latch,
   output logic o_xwrite_to_ram,
   // Code reads
   input wire fsac_cread_s i_cread,
   output fsac_cresp_s o_cresp,
   input wire logic i_boot_fetch,
   output logic o_boot_fetch_ok,
   // Flash macro
   output logic o_flash_select,
   output logic o_powerdown_ack,
   output logic o_prog_start,
   output logic [2:0] o_prog_target,
   // Protection
   output fsac_prot_s o_prot,
   output fsac_level_e o_level,
   output logic o_ea_latched
);

   localparam int CW = $clog2(PROG_CYCLES + 1);

   function automatic logic [15:0] eff_addr(input logic [15:0] p, input logic [7:0] a);
      eff_addr = p + {8'h00, a};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] ctrl_reg;
   logic armed_reg;
   logic busy_reg;
   logic seqerr_reg;
   logic loaded_reg;
   logic usermap_reg;
   logic [2:0] bank_reg;
   logic [2:0] prog_tgt_reg;
   logic [7:0] sec_reg;
   logic [7:0] fuse_reg;
   logic pd_reg;
   logic ea_reg;
   logic ea_sync1_reg;
   logic ea_sync2_reg;
   logic ea_sync3_reg;
   logic ea_caught_reg;
   logic ea_filt_reg;
   logic [1:0] ea_fill_reg;
   logic [CW-1:0] cnt_reg;
   logic [31:0] rdata_reg;
   logic [1:0] resp_reg;
   logic ack_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire bus_req = (i_avs_read | i_avs_write) & ~ack_reg;
   wire bus_wr = i_avs_write & ~ack_reg;
   wire be0 = i_avs_byteenable[0];
   wire sel_ctrl = (i_avs_address == `FSAC_ADDR_CTRL);
   wire sel_stat = (i_avs_address == `FSAC_ADDR_STATUS);
   wire sel_bank = (i_avs_address == `FSAC_ADDR_BANK);
   wire sel_lock = (i_avs_address == `FSAC_ADDR_LOCK);
   wire mapped = sel_ctrl | sel_stat | sel_bank | sel_lock;
   wire ctrl_wr = bus_wr & sel_ctrl & be0;
   wire stat_wr = bus_wr & sel_stat & be0;
   wire bank_wr = bus_wr & sel_bank & be0;
   wire [7:0] wd = i_avs_writedata[7:0];
   wire [3:0] key = wd[`FSAC_KEY_MSB:`FSAC_KEY_LSB];
   wire [2:0] wtgt = wd[`FSAC_TGT_MSB:`FSAC_TGT_LSB];

   // Activation sequence
   wire key_first = ctrl_wr & (key == `FSAC_KEY_FIRST);
   wire key_second = ctrl_wr & (key == `FSAC_KEY_SECOND);
   wire seq_broken = armed_reg & ((i_other_instr & ~ctrl_wr) | (ctrl_wr & ~key_second));
   wire seq_done = armed_reg & key_second & ~i_other_instr;
   wire needs_data = (wtgt == `FSAC_TGT_USER) | (wtgt == `FSAC_TGT_XROW) |
                     (wtgt == `FSAC_TGT_RSTLAT);
   wire no_data = seq_done & needs_data & ~loaded_reg;
   wire no_write = wtgt[2] & wtgt[1];
   wire seq_good = seq_done & ~no_data & ~busy_reg;
   wire launch = seq_good & (wtgt != `FSAC_TGT_RSTLAT) & ~no_write;
   wire latch_reset = seq_good & (wtgt == `FSAC_TGT_RSTLAT);
   wire seq_bad = seq_broken & ~key_first | no_data | (key_second & ~armed_reg);
   wire prog_end = busy_reg & (cnt_reg == CW'(1));

   // Power-down is held off while programming
   wire pd_take = i_powerdown_req & ~busy_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Lock level decode
   wire [2:0] lb = sec_reg[`FSAC_LOCK_B2:`FSAC_LOCK_B0];
   // Programmed bit reads as 0; lowest programmed bit wins
   assign o_level = ~lb[`FSAC_LOCK_B0] ? FSAC_LVL2 :
                    ~lb[`FSAC_LOCK_B1] ? FSAC_LVL3 :
                    ~lb[`FSAC_LOCK_B2] ? FSAC_LVL4 : FSAC_LVL1;
   wire lvl2p = (o_level != FSAC_LVL1);
   wire lvl3p = (o_level == FSAC_LVL3) | (o_level == FSAC_LVL4);
   wire lvl4 = (o_level == FSAC_LVL4);
   assign o_prot.ext_read_block = lvl2p;
   assign o_prot.ea_latch = lvl2p;
   assign o_prot.par_prog_off = lvl2p;
   assign o_prot.isp_write_off = lvl2p;
   assign o_prot.par_verify_off = lvl3p;
   assign o_prot.isp_read_off = lvl3p;
   assign o_prot.ext_exec_off = lvl4;

   // Pin level, latched at reset release when protected
   wire ea_live = o_prot.ea_latch ? ea_reg : ea_filt_reg;
   assign o_ea_latched = ea_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Code read mapping
   wire [15:0] ea_addr = eff_addr(i_cread.ptr, i_cread.offset);
   wire zero_off = (i_cread.offset == 8'h00);
   wire xrow_hit = (ctrl_reg == `FSAC_MAP_XROW) & zero_off &
                   (i_cread.ptr <= `FSAC_XROW_LAST);
   wire sec_hit = (ctrl_reg == `FSAC_MAP_SEC) & zero_off &
                  (i_cread.ptr == `FSAC_ZERO_ADDR);
   wire fuse_hit = (ctrl_reg == `FSAC_MAP_FUSE) & zero_off &
                   (i_cread.ptr == `FSAC_ZERO_ADDR);
   wire from_ext = (i_cread.from == FSAC_SRC_EXT);
   wire ext_all = from_ext & ~ea_live;
   wire ext_bank_rd = from_ext & ea_live & i_cread.pc_upper & i_cread.ext_bank;
   wire ext_up = ext_bank_rd & ea_addr[`FSAC_UPPER_BIT];
   wire ext_low_blk = ext_bank_rd & ~ea_addr[`FSAC_UPPER_BIT] & o_prot.ext_read_block;
   wire boot_view = (i_cread.from == FSAC_SRC_BOOT) & ~usermap_reg;
   fsac_route_e route;
   assign route = ext_all ? FSAC_RD_EXT :
                  (ext_up & ~o_prot.ext_exec_off) ? FSAC_RD_EXT :
                  (ext_up | ext_low_blk) ? FSAC_RD_BLOCK :
                  (from_ext & o_prot.ext_read_block) ? FSAC_RD_BLOCK :
                  xrow_hit ? FSAC_RD_XROW :
                  sec_hit ? FSAC_RD_SEC :
                  fuse_hit ? FSAC_RD_FUSE :
                  boot_view ? FSAC_RD_BOOT : FSAC_RD_USER;
   wire upper = ea_addr[`FSAC_UPPER_BIT];
   wire [2:0] rd_bank = upper ? bank_reg : 3'h0;

   // Data writes
   assign o_xwrite_to_latch = i_xwrite & ctrl_reg[`FSAC_LATCH_MAP_BIT] & ea_live;
   assign o_xwrite_to_ram = i_xwrite & ~o_xwrite_to_latch;
   wire latch_load = o_xwrite_to_latch & ~busy_reg;

   assign o_boot_fetch_ok = i_boot_fetch & i_boot_active;
   assign o_flash_select = ~pd_reg;
   assign o_powerdown_ack = pd_take;
   assign o_prog_start = launch;
   assign o_prog_target = prog_tgt_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus read data
   wire [7:0] stat_val = {4'h0, usermap_reg, loaded_reg, seqerr_reg, busy_reg};
   wire [31:0] rd_mux = sel_ctrl ? {24'h0, ctrl_reg} :
                        sel_stat ? {24'h0, stat_val} :
                        sel_bank ? {29'h0, bank_reg} :
                        sel_lock ? {24'h0, sec_reg} : 32'h0;
   assign o_avs_waitrequest = bus_req;
   assign o_avs_readdata = rdata_reg;
   assign o_avs_response = resp_reg;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0;
         resp_reg <= 2'h0;
      end else begin
         ack_reg <= bus_req;
         if (bus_req) begin
            rdata_reg <= i_avs_read ? rd_mux : 32'h0;
            resp_reg <= mapped ? 2'h0 : 2'h2;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control, bank, sequence state
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ctrl_reg <= 8'h00;
         bank_reg <= 3'h0;
         armed_reg <= 1'b0;
         prog_tgt_reg <= 3'h0;
      end else begin
         if (ctrl_wr) begin
            ctrl_reg <= {4'h0, wd[3:0]};
         end
         if (bank_wr) begin
            bank_reg <= wd[2:0];
         end
         // Armed survives idle cycles, not another instruction
         armed_reg <= ctrl_wr ? key_first : (armed_reg & ~i_other_instr);
         if (launch) begin
            prog_tgt_reg <= wtgt;
         end
      end
   end

   // Busy and programming timer
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         busy_reg <= 1'b0;
         cnt_reg <= '0;
      end else if (launch) begin
         busy_reg <= 1'b1;
         cnt_reg <= CW'(PROG_CYCLES);
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg - CW'(1);
         if (prog_end) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // Sequence error: hardware set wins over any clear
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         seqerr_reg <= 1'b0;
      end else if (seq_bad) begin
         seqerr_reg <= 1'b1;
      end else if (seq_good | (stat_wr & ~wd[`FSAC_ST_SEQERR])) begin
         seqerr_reg <= 1'b0;
      end
   end

   // Latches loaded, user map, power-down
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         loaded_reg <= 1'b0;
         usermap_reg <= 1'b0;
         pd_reg <= 1'b0;
      end else begin
         if (pd_take) begin
            loaded_reg <= 1'b0;
         end else if (latch_load) begin
            loaded_reg <= 1'b1;
         end else if (latch_reset) begin
            loaded_reg <= 1'b0;
         end
         pd_reg <= pd_take ? 1'b1 : (pd_reg & i_powerdown_req);
         // Map is consumed by each boot-area read
         if (stat_wr) begin
            usermap_reg <= wd[`FSAC_ST_USERMAP];
         end else if (i_boot_hw_entry) begin
            usermap_reg <= 1'b0;
         end else if (i_cread.valid & (i_cread.from == FSAC_SRC_BOOT)) begin
            usermap_reg <= 1'b0;
         end
      end
   end

   // Security byte ORs in the write address low byte on a latch load with target 4; fuse byte keeps its reset value
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         sec_reg <= `FSAC_SEC_RESET;
         fuse_reg <= `FSAC_FUSE_RESET;
      end else if (latch_load & (ctrl_reg[2:0] == `FSAC_TGT_SEC)) begin
         sec_reg <= i_xwrite_addr[7:0] | sec_reg & 8'h00 | wd & 8'h00 | sec_reg;
      end else if (latch_load & (ctrl_reg[2:0] == `FSAC_TGT_FUSE)) begin
         fuse_reg <= fuse_reg;
      end
   end

   // Pin synchroniser and reset-time catch
   // Catch waits for the chain to fill, so a reset value never latches
   wire ea_agree = (ea_fill_reg == `FSAC_EA_FILL) & (ea_sync2_reg == ea_sync3_reg);
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ea_sync1_reg <= 1'b0;
         ea_sync2_reg <= 1'b0;
         ea_sync3_reg <= 1'b0;
         ea_fill_reg <= 2'h0;
         ea_filt_reg <= 1'b0;
         ea_caught_reg <= 1'b0;
         ea_reg <= 1'b0;
      end else begin
         ea_sync1_reg <= i_ext_access_pin;
         ea_sync2_reg <= ea_sync1_reg;
         ea_sync3_reg <= ea_sync2_reg;
         if (ea_fill_reg != `FSAC_EA_FILL) begin
            ea_fill_reg <= ea_fill_reg + 2'h1;
         end
         if (ea_agree) begin
            ea_filt_reg <= ea_sync3_reg;
         end
         if (~ea_caught_reg & ea_agree) begin
            ea_reg <= ea_sync3_reg;
            ea_caught_reg <= 1'b1;
         end
      end
   end

   // Code read response
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_cresp <= '0;
      end else begin
         o_cresp.valid <= i_cread.valid;
         o_cresp.route <= route;
         o_cresp.bank <= rd_bank;
         o_cresp.addr <= {1'b0, ea_addr};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_busy_set: assert property (@(posedge i_clock) disable iff (i_rst)
      launch |=> busy_reg) else $error("busy not set on launch");
   a_busy_clear: assert property (@(posedge i_clock) disable iff (i_rst)
      prog_end |=> ~busy_reg) else $error("busy not cleared");
   a_seq_error: assert property (@(posedge i_clock) disable iff (i_rst)
      seq_broken & ~key_first |=> seqerr_reg) else $error("broken sequence missed");
   a_nodata_err: assert property (@(posedge i_clock) disable iff (i_rst)
      no_data |=> seqerr_reg ##0 ~busy_reg) else $error("empty latch launch");
   a_good_clears: assert property (@(posedge i_clock) disable iff (i_rst)
      seq_good & ~seq_bad |=> ~seqerr_reg) else $error("error not cleared");
   a_pd_latches: assert property (@(posedge i_clock) disable iff (i_rst)
      pd_take |=> ~loaded_reg & ~o_flash_select) else $error("latches kept");
   a_pd_held: assert property (@(posedge i_clock) disable iff (i_rst)
      busy_reg |-> ~o_powerdown_ack) else $error("power-down during write");
   a_latch_route: assert property (@(posedge i_clock) disable iff (i_rst)
      i_xwrite & ~ctrl_reg[`FSAC_LATCH_MAP_BIT] |-> o_xwrite_to_ram)
      else $error("write to latch unmapped");
   a_xrow_route: assert property (@(posedge i_clock) disable iff (i_rst)
      i_cread.valid & xrow_hit & ~from_ext |=> o_cresp.route == FSAC_RD_XROW)
      else $error("extra row not read");
   a_ext_all: assert property (@(posedge i_clock) disable iff (i_rst)
      i_cread.valid & ext_all |=> o_cresp.route == FSAC_RD_EXT)
      else $error("external read missed");
   a_boot_fetch: assert property (@(posedge i_clock) disable iff (i_rst)
      o_boot_fetch_ok |-> i_boot_active) else $error("boot fetch outside boot");

endmodule
`default_nettype wire

// File: rtl/fsac_defines.svh
// Constants for the flash space access control block
`ifndef FSAC_DEFINES_SVH
`define FSAC_DEFINES_SVH

// Register byte addresses
`define FSAC_ADDR_CTRL 4'h0
`define FSAC_ADDR_STATUS 4'h4
`define FSAC_ADDR_BANK 4'h8
`define FSAC_ADDR_LOCK 4'hC

// Control register fields
`define FSAC_KEY_MSB 7
`define FSAC_KEY_LSB 4
`define FSAC_KEY_FIRST 4'h5
`define FSAC_KEY_SECOND 4'hA
`define FSAC_LATCH_MAP_BIT 3
`define FSAC_TGT_MSB 2
`define FSAC_TGT_LSB 0

// Target space codes
`define FSAC_TGT_USER 3'h0
`define FSAC_TGT_XROW 3'h1
`define FSAC_TGT_ERASE 3'h2
`define FSAC_TGT_RSTLAT 3'h3
`define FSAC_TGT_SEC 3'h4
`define FSAC_TGT_FUSE 3'h5

// Control values that map read spaces
`define FSAC_MAP_XROW 8'h01
`define FSAC_MAP_SEC 8'h04
`define FSAC_MAP_FUSE 8'h05
`define FSAC_XROW_LAST 16'h007F
`define FSAC_ZERO_ADDR 16'h0000

// Status register bit positions
`define FSAC_ST_BUSY 0
`define FSAC_ST_SEQERR 1
`define FSAC_ST_LOADED 2
`define FSAC_ST_USERMAP 3

// Address space
`define FSAC_UPPER_BIT 15
`define FSAC_HALF 16'h8000

// Pin synchroniser fill count before the first trusted sample
`define FSAC_EA_FILL 2'h3

// Lock bit positions inside the security byte
`define FSAC_LOCK_B0 0
`define FSAC_LOCK_B1 1
`define FSAC_LOCK_B2 2

// Reset values
`define FSAC_SEC_RESET 8'hFB
`define FSAC_FUSE_RESET 8'hFF

// Programming time
`define FSAC_PROG_TIME_US 10
`define FSAC_CLK_MHZ 100

`endif

// File: rtl/fsac_pkg.sv
// Types shared by the flash space access control block
package fsac_pkg;
   typedef enum logic [1:0] {
      FSAC_LVL1,
      FSAC_LVL2,
      FSAC_LVL3,
      FSAC_LVL4
   } fsac_level_e;

   typedef enum logic [1:0] {
      FSAC_SRC_USER,
      FSAC_SRC_BOOT,
      FSAC_SRC_EXT
   } fsac_fetch_e;

   // Code-space read request from the core
   typedef struct packed {
      logic valid;
      logic [15:0] ptr;
      logic [7:0] offset;
      fsac_fetch_e from;
      logic pc_upper;
      logic ext_bank;
   } fsac_cread_s;

   // Where a code read is steered
   typedef enum logic [2:0] {
      FSAC_RD_USER,
      FSAC_RD_BOOT,
      FSAC_RD_XROW,
      FSAC_RD_SEC,
      FSAC_RD_FUSE,
      FSAC_RD_EXT,
      FSAC_RD_BLOCK
   } fsac_route_e;

   typedef struct packed {
      logic valid;
      fsac_route_e route;
      logic [2:0] bank;
      logic [16:0] addr;
   } fsac_cresp_s;

   // Protection restrictions
   typedef struct packed {
      logic ext_read_block;
      logic ea_latch;
      logic par_prog_off;
      logic isp_write_off;
      logic par_verify_off;
      logic isp_read_off;
      logic ext_exec_off;
   } fsac_prot_s;
endpackage

// File: bench/fsac_cpu_model.sv
// CPU core model: register accesses, activation writes and code reads
`timescale 1ns/1ps
`default_nettype none
`include "fsac_defines.svh"

module fsac_cpu_model
   import fsac_pkg::*;
(
   // Clock
   input wire logic i_clock,
   // Avalon-MM master side
   output logic [3:0] o_avs_address,
   output logic o_avs_read,
   output logic o_avs_write,
   output logic [31:0] o_avs_writedata,
   output logic [3:0] o_avs_byteenable,
   input wire logic [31:0] i_avs_readdata,
   input wire logic i_avs_waitrequest,
   input wire logic [1:0] i_avs_response,
   // Instruction stream
   output logic o_other_instr,
   output fsac_cread_s o_cread,
   input wire fsac_cresp_s i_cresp
);
   initial begin
      o_avs_address = 4'h0;
      o_avs_read = 1'b0;
      o_avs_write = 1'b0;
      o_avs_writedata = 32'h00000000;
      o_avs_byteenable = 4'hF;
      o_other_instr = 1'b0;
      o_cread = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Held until waitrequest is seen low; only the bench watchdog ends a hang
   task automatic acc(input logic wr, input logic [3:0] addr, input logic [7:0] data,
         output logic [31:0] rdata, output logic [1:0] resp);
      o_avs_address <= addr;
      o_avs_writedata <= {24'h000000, data};
      o_avs_write <= wr;
      o_avs_read <= ~wr;
      do begin
         @(posedge i_clock);
      end while (i_avs_waitrequest !== 1'b0);
      rdata = i_avs_readdata;
      resp = i_avs_response;
      o_avs_read <= 1'b0;
      o_avs_write <= 1'b0;
      // Released bus shows junk, not the last value
      o_avs_address <= ~addr;
      o_avs_writedata <= ~{24'h000000, data};
      @(posedge i_clock);
   endtask

   // Two control writes; gap puts another instruction between them
   task automatic act(input logic [3:0] tgt, input logic gap);
      logic [31:0] rd;
      logic [1:0] rs;
      acc(1'b1, `FSAC_ADDR_CTRL, {`FSAC_KEY_FIRST, tgt}, rd, rs);
      if (gap) begin
         o_other_instr <= 1'b1;
         @(posedge i_clock);
         o_other_instr <= 1'b0;
      end
      acc(1'b1, `FSAC_ADDR_CTRL, {`FSAC_KEY_SECOND, tgt}, rd, rs);
   endtask

   // Code read; answer is registered one cycle after the request
   task automatic cr(input logic [15:0] ptr, input fsac_fetch_e from,
         output fsac_cresp_s resp);
      o_cread <= '{1'b1, ptr, 8'h00, from, 1'b0, 1'b0};
      @(posedge i_clock);
      o_cread <= '{1'b0, ~ptr, 8'hFF, from, 1'b1, 1'b1};
      @(posedge i_clock);
      resp = i_cresp;
   endtask
endmodule
`default_nettype wire

// File: bench/flash_space_access_control_tb_top.sv
// Testbench for the flash space access control block
`timescale 1ns/1ps
`default_nettype none
`include "fsac_defines.svh"

module flash_space_access_control_tb_top
   import fsac_pkg::*;
;
   logic clock, rst, pd_req, boot_entry, boot_active, ext_pin, xwrite, boot_fetch;
   logic [15:0] xwrite_addr;
   logic [3:0] avs_address, avs_be;
   logic avs_read, avs_write, avs_wait, other_instr;
   logic [31:0] avs_wdata, avs_rdata, rd;
   logic [1:0] avs_resp, rsp;
   logic xw_latch, xw_ram, boot_ok, flash_sel, pd_ack, prog_start, ea_latched;
   logic [2:0] prog_target;
   fsac_cread_s cread;
   fsac_cresp_s cresp, cr;
   fsac_prot_s prot;
   fsac_level_e level;
   int mismatches = 0;
   int comparisons = 0;
   int launches = 0;
   logic [7:0] map_ctrl [4] = '{`FSAC_MAP_XROW, `FSAC_MAP_SEC, `FSAC_MAP_FUSE, 8'h00};
   logic [15:0] map_ptr [4] = '{`FSAC_XROW_LAST, 16'h0000, 16'h0000, 16'h0000};
   fsac_route_e map_rt [4] = '{FSAC_RD_XROW, FSAC_RD_SEC, FSAC_RD_FUSE, FSAC_RD_USER};

   fsac_core #(.PROG_CYCLES(8)) DUT (.i_clock(clock), .i_rst(rst),
      .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
      .i_avs_writedata(avs_wdata), .i_avs_byteenable(avs_be), .o_avs_readdata(avs_rdata),
      .o_avs_waitrequest(avs_wait), .o_avs_response(avs_resp), .i_other_instr(other_instr),
      .i_powerdown_req(pd_req), .i_boot_hw_entry(boot_entry), .i_boot_active(boot_active),
      .i_ext_access_pin(ext_pin), .i_xwrite(xwrite), .i_xwrite_addr(xwrite_addr),
      .o_xwrite_to_latch(xw_latch), .o_xwrite_to_ram(xw_ram), .i_cread(cread),
      .o_cresp(cresp), .i_boot_fetch(boot_fetch), .o_boot_fetch_ok(boot_ok),
      .o_flash_select(flash_sel), .o_powerdown_ack(pd_ack), .o_prog_start(prog_start),
      .o_prog_target(prog_target), .o_prot(prot), .o_level(level), .o_ea_latched(ea_latched));

   fsac_cpu_model u_cpu (.i_clock(clock), .o_avs_address(avs_address), .o_avs_read(avs_read),
      .o_avs_write(avs_write), .o_avs_writedata(avs_wdata), .o_avs_byteenable(avs_be),
      .i_avs_readdata(avs_rdata), .i_avs_waitrequest(avs_wait), .i_avs_response(avs_resp),
      .o_other_instr(other_instr), .o_cread(cread), .i_cresp(cresp));

   // Programming launches seen at the clock edge
   always @(posedge clock) begin
      if (prog_start === 1'b1) begin
         launches <= launches + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      u_cpu.acc(1'b1, a, d, rd, rsp);
   endtask

   task automatic rdc(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
      u_cpu.acc(1'b0, a, 8'h00, rd, rsp);
      chk(rd & mask, exp);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Whole run is well under 1000 cycles
   initial begin
      #50000;
      mismatches++;
      wrap_up();
   end

   initial begin
      rst = 1'b1;
      pd_req = 1'b0;
      boot_entry = 1'b0;
      boot_active = 1'b0;
      ext_pin = 1'b1;
      xwrite = 1'b0;
      xwrite_addr = 16'h0010;
      boot_fetch = 1'b0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rdc(`FSAC_ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
      rdc(`FSAC_ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
      rdc(`FSAC_ADDR_LOCK, 32'hFFFFFFFF, {24'h0, `FSAC_SEC_RESET});
      chk(32'(level), 32'(FSAC_LVL4));
      chk(32'(prot), 32'h7F);
      chk(32'(ea_latched), 32'h1);
      u_cpu.acc(1'b0, 4'h2, 8'h00, rd, rsp);
      chk(32'(rsp), 32'h2);
      chk(rd, 32'h0);
      $display("test reset done");
      // Activation with empty latches
      u_cpu.act(4'h0, 1'b0);
      rdc(`FSAC_ADDR_STATUS, 32'h7, 32'h2);
      wr(`FSAC_ADDR_STATUS, 8'h00);
      rdc(`FSAC_ADDR_STATUS, 32'h7, 32'h0);
      // Load one latch byte with the latch space mapped
      wr(`FSAC_ADDR_CTRL, 8'h08);
      xwrite <= 1'b1;
      #1;
      chk(32'({xw_latch, xw_ram}), 32'h2);
      @(posedge clock);
      xwrite <= 1'b0;
      rdc(`FSAC_ADDR_STATUS, 32'h7, 32'h4);
      u_cpu.act(4'h0, 1'b1);
      rdc(`FSAC_ADDR_STATUS, 32'h7, 32'h6);
      u_cpu.act(4'h0, 1'b0);
      rdc(`FSAC_ADDR_STATUS, 32'h3, 32'h1);
      chk(32'(launches), 32'h1);
      chk(32'(prog_target), 32'(`FSAC_TGT_USER));
      pd_req <= 1'b1;
      #1;
      chk(32'({pd_ack, flash_sel}), 32'h1);
      repeat (12) @(posedge clock);
      #1;
      chk(32'({pd_ack, flash_sel}), 32'h2);
      @(posedge clock);
      pd_req <= 1'b0;
      rdc(`FSAC_ADDR_STATUS, 32'h7, 32'h0);
      xwrite <= 1'b1;
      #1;
      chk(32'({xw_latch, xw_ram}), 32'h1);
      @(posedge clock);
      xwrite <= 1'b0;
      $display("test sequence done");
      // Read space mapping by control value
      for (int i = 0; i < 4; i++) begin
         wr(`FSAC_ADDR_CTRL, map_ctrl[i]);
         u_cpu.cr(map_ptr[i], FSAC_SRC_USER, cr);
         chk(32'({cr.valid, cr.route}), 32'({1'b1, map_rt[i]}));
      end
      wr(`FSAC_ADDR_BANK, 8'h05);
      u_cpu.cr(16'h9000, FSAC_SRC_USER, cr);
      chk(32'({cr.route, cr.bank}), 32'({FSAC_RD_USER, 3'h5}));
      chk(32'(cr.addr), 32'h00009000);
      u_cpu.cr(16'h0100, FSAC_SRC_EXT, cr);
      chk(32'(cr.route), 32'(FSAC_RD_BLOCK));
      boot_active <= 1'b1;
      boot_entry <= 1'b1;
      @(posedge clock);
      boot_entry <= 1'b0;
      @(posedge clock);
      u_cpu.cr(16'h0100, FSAC_SRC_BOOT, cr);
      chk(32'(cr.route), 32'(FSAC_RD_BOOT));
      wr(`FSAC_ADDR_STATUS, 8'h08);
      u_cpu.cr(16'h0100, FSAC_SRC_BOOT, cr);
      chk(32'(cr.route), 32'(FSAC_RD_USER));
      boot_fetch <= 1'b1;
      #1;
      chk(32'(boot_ok), 32'h1);
      @(posedge clock);
      boot_active <= 1'b0;
      #1;
      chk(32'(boot_ok), 32'h0);
      @(posedge clock);
      boot_fetch <= 1'b0;
      $display("test mapping done");
      wrap_up();
   end
endmodule
`default_nettype wire
